// >>> rtl/shpp_far_end.sv
// Purpose: far end of the serial host port: spi master/slave or i2c master
// Assumes: one clock, serial clocks made by dividing it
// Notes: one i2c frame is address, one data byte, stop
`timescale 1ns/10ps
module shpp_far_end
   import shpp_pkg::*;
(
   input wire logic CLOCK_IN,
   input wire logic RST_IN,
   input wire logic I2C_MODE_IN,
   input wire logic MASTER_IN,
   input wire logic START_IN,
   input wire logic [6:0] ADDR_IN,
   input wire logic READ_IN,
   input wire logic [7:0] TX_DATA_IN,
   input wire logic ADDR_SEL_IN,
   input wire logic SS_FORCE_IN,
   output logic BUSY_OUT,
   output logic [7:0] RX_DATA_OUT,
   output logic RX_VALID_OUT,
   output logic ACK_OK_OUT,
   shpp_link_if.par LINK
);
   typedef enum logic [2:0] {P_IDLE, P_SPI_M, P_START, P_BIT, P_STOP} shpp_pstate_e;

   typedef struct packed {
      shpp_pstate_e st;
      logic [7:0] q;
      logic [1:0] ph;
      logic [4:0] idx;
      logic [7:0] addr_b;
      logic [7:0] shift_out;
      logic [7:0] shift_in;
      logic rd;
      logic sck_o;
      logic mosi_o;
      logic ss_act;
      logic scl_oe;
      logic sda_oe;
      logic asel;
      logic [7:0] rx_data;
      logic rx_valid;
      logic ack_ok;
   } shpp_par_s;

   shpp_par_s pr_reg, pr_next;
   logic [3:0] s1_reg, s2_reg;
   logic sck_p_reg;
   logic sck_s, mosi_s, miso_s, sda_s, tick, bitval, sck_rise, sck_fall;

   always_ff @(posedge CLOCK_IN) begin
      s1_reg <= {LINK.sck, LINK.mosi, LINK.miso, LINK.sda};
      s2_reg <= s1_reg;
      sck_p_reg <= s2_reg[3];
   end

   assign {sck_s, mosi_s, miso_s, sda_s} = s2_reg;
   assign sck_rise = sck_s & ~sck_p_reg;
   assign sck_fall = ~sck_s & sck_p_reg;
   assign tick = (pr_reg.q == SHPP_PAR_QUARTER - 8'h01);

   // level for i2c bit idx: address byte, ack, data or released, ack/nack released
   always_comb begin
      bitval = 1'h1;
      if (pr_reg.idx < SHPP_I2C_ADDR_ACK) begin
         bitval = pr_reg.addr_b[3'h7 - pr_reg.idx[2:0]];
      end else if (pr_reg.idx > SHPP_I2C_ADDR_ACK && pr_reg.idx <= SHPP_I2C_DATA_LAST && !pr_reg.rd) begin
         bitval = pr_reg.shift_out[3'h0 - pr_reg.idx[2:0]];
      end
   end

   always_comb begin
      pr_next = pr_reg;
      pr_next.rx_valid = 1'h0;
      pr_next.asel = ADDR_SEL_IN;
      pr_next.q = (tick || pr_reg.st == P_IDLE) ? 8'h00 : pr_reg.q + 8'h01;
      if (tick) begin
         pr_next.ph = pr_reg.ph + 2'h1;
      end
      case (pr_reg.st)
         P_IDLE: begin
            pr_next.ph = 2'h0;
            pr_next.ss_act = SS_FORCE_IN;
            if (START_IN) begin
               pr_next.idx = 5'h00;
               pr_next.shift_out = TX_DATA_IN;
               pr_next.addr_b = {ADDR_IN, READ_IN};
               pr_next.rd = READ_IN;
               pr_next.ack_ok = 1'h1;
               if (!I2C_MODE_IN && MASTER_IN) begin
                  pr_next.st = P_SPI_M;
                  pr_next.ss_act = 1'h1;
                  pr_next.mosi_o = TX_DATA_IN[7];
               end else if (I2C_MODE_IN && MASTER_IN) begin
                  pr_next.st = P_START;
                  pr_next.sda_oe = 1'h1;
               end
            end else if (!I2C_MODE_IN && !MASTER_IN) begin
               // spi slave: shift on falling sck, sample on rising
               if (sck_rise) begin
                  pr_next.shift_in = {pr_reg.shift_in[6:0], mosi_s};
                  pr_next.idx = pr_reg.idx + 5'h01;
                  if (pr_reg.idx[2:0] == 3'h7) begin
                     pr_next.rx_data = {pr_reg.shift_in[6:0], mosi_s};
                     pr_next.rx_valid = 1'h1;
                  end
               end else if (sck_fall) begin
                  pr_next.shift_out = {pr_reg.shift_out[6:0], 1'h0};
               end
               pr_next.idx[4:3] = 2'h0;
            end else begin
               // the slave bit count must survive idle cycles, other roles restart from zero
               pr_next.idx = 5'h00;
            end
         end
         P_SPI_M: begin
            if (tick && pr_reg.ph == 2'h1) begin
               pr_next.sck_o = 1'h1;
               pr_next.shift_in = {pr_reg.shift_in[6:0], miso_s};
            end else if (tick && pr_reg.ph == SHPP_PHASE_LAST) begin
               pr_next.sck_o = 1'h0;
               pr_next.idx = pr_reg.idx + 5'h01;
               pr_next.shift_out = {pr_reg.shift_out[6:0], 1'h0};
               pr_next.mosi_o = pr_reg.shift_out[6];
               if (pr_reg.idx[2:0] == 3'h7) begin
                  pr_next.rx_data = pr_reg.shift_in;
                  pr_next.rx_valid = 1'h1;
                  pr_next.ss_act = 1'h0;
                  pr_next.st = P_IDLE;
               end
            end
         end
         P_START: begin
            if (tick) begin
               pr_next.scl_oe = 1'h1;
               pr_next.ph = 2'h0;
               pr_next.st = P_BIT;
            end
         end
         P_BIT: begin
            if (tick) begin
               case (pr_reg.ph)
                  2'h0: pr_next.sda_oe = ~bitval;
                  2'h1: pr_next.scl_oe = 1'h0;
                  2'h2: begin
                     pr_next.shift_in = {pr_reg.shift_in[6:0], sda_s};
                     if (pr_reg.idx == SHPP_I2C_ADDR_ACK || (pr_reg.idx == SHPP_I2C_LAST && !pr_reg.rd)) begin
                        pr_next.ack_ok = pr_reg.ack_ok & ~sda_s;
                     end
                     if (pr_reg.idx == SHPP_I2C_DATA_LAST && pr_reg.rd) begin
                        pr_next.rx_data = {pr_reg.shift_in[6:0], sda_s};
                        pr_next.rx_valid = 1'h1;
                     end
                  end
                  default: begin
                     pr_next.scl_oe = 1'h1;
                     pr_next.idx = pr_reg.idx + 5'h01;
                     if (pr_reg.idx == SHPP_I2C_LAST || (pr_reg.idx == SHPP_I2C_ADDR_ACK && !pr_reg.ack_ok)) begin
                        pr_next.st = P_STOP;
                     end
                  end
               endcase
            end
         end
         P_STOP: begin
            if (tick) begin
               case (pr_reg.ph)
                  2'h0: pr_next.sda_oe = 1'h1;
                  2'h1: pr_next.scl_oe = 1'h0;
                  2'h2: pr_next.sda_oe = 1'h0;
                  default: pr_next.st = P_IDLE;
               endcase
            end
         end
         default: begin
            pr_next.st = P_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         pr_reg <= '0;
      end else begin
         pr_reg <= pr_next;
      end
   end

   assign BUSY_OUT = pr_reg.st != P_IDLE;
   assign RX_DATA_OUT = pr_reg.rx_data;
   assign RX_VALID_OUT = pr_reg.rx_valid;
   assign ACK_OK_OUT = pr_reg.ack_ok;
   assign LINK.sck_par_o = pr_reg.sck_o;
   assign LINK.sck_par_oe = ~I2C_MODE_IN & MASTER_IN & ~RST_IN;
   assign LINK.mosi_par_o = pr_reg.mosi_o;
   assign LINK.mosi_par_oe = ~I2C_MODE_IN & MASTER_IN & ~RST_IN;
   assign LINK.miso_par_o = pr_reg.shift_out[7];
   assign LINK.miso_par_oe = ~I2C_MODE_IN & ~MASTER_IN & ~RST_IN;
   assign LINK.sda_par_oe = pr_reg.sda_oe & I2C_MODE_IN;
   assign LINK.scl_par_oe = pr_reg.scl_oe & I2C_MODE_IN;
   assign LINK.ss_n_par_o = ~pr_reg.ss_act;
   assign LINK.addr_sel_par_o = pr_reg.asel;
endmodule

// >>> rtl/shpp_link_if.sv
// Purpose: pins between the serial host port and the far end
// Assumes: pull-ups on mosi, miso, scl and sda; sck rests low
// Notes: scl and sda are open drain, an enable means pulling low
`timescale 1ns/10ps
interface shpp_link_if;
   logic sck_dev_o, sck_dev_oe, sck_par_o, sck_par_oe;
   logic mosi_dev_o, mosi_dev_oe, mosi_par_o, mosi_par_oe;
   logic miso_dev_o, miso_dev_oe, miso_par_o, miso_par_oe;
   logic sda_dev_oe, sda_par_oe, scl_par_oe;
   logic ss_n_par_o, addr_sel_par_o;
   logic sck, mosi, miso, sda, scl, ss_n, i2c_slave_addr_select_0;

   assign sck = sck_dev_oe ? sck_dev_o : (sck_par_oe ? sck_par_o : 1'h0);
   assign mosi = mosi_dev_oe ? mosi_dev_o : (mosi_par_oe ? mosi_par_o : 1'h1);
   assign miso = miso_dev_oe ? miso_dev_o : (miso_par_oe ? miso_par_o : 1'h1);
   assign sda = ~(sda_dev_oe | sda_par_oe);
   assign scl = ~scl_par_oe;
   assign ss_n = ss_n_par_o;
   assign i2c_slave_addr_select_0 = addr_sel_par_o;

   modport dev (
      output sck_dev_o, sck_dev_oe, mosi_dev_o, mosi_dev_oe, miso_dev_o, miso_dev_oe, sda_dev_oe,
      input sck, mosi, miso, sda, scl, ss_n, i2c_slave_addr_select_0
   );
   modport par (
      output sck_par_o, sck_par_oe, mosi_par_o, mosi_par_oe, miso_par_o, miso_par_oe, sda_par_oe,
      output scl_par_oe, ss_n_par_o, addr_sel_par_o,
      input sck, mosi, miso, sda
   );
endinterface

// >>> rtl/shpp_pkg.sv
// Purpose: shared constants for the serial host port pin block
// Assumes: both ends import this package whole
// Notes: serial clock divisors are local choices, not pin timing limits
package shpp_pkg;
   // bits in one serial byte
   localparam logic [3:0] SHPP_BYTE_BITS = 4'h8;
   // device as spi master: link clock cycles per sck half period
   localparam logic [7:0] SHPP_DEV_SCK_HALF = 8'h04;
   // far end: clock cycles per quarter of one serial bit
   localparam logic [7:0] SHPP_PAR_QUARTER = 8'h20;
   // upper six bits of the device's own i2c address, bit 0 comes from the select pin
   localparam logic [6:0] SHPP_ADDR_BASE = 7'h48;
   // far end i2c frame: address byte, ack, data byte, ack
   localparam logic [4:0] SHPP_I2C_ADDR_ACK = 5'h08;
   localparam logic [4:0] SHPP_I2C_DATA_LAST = 5'h10;
   localparam logic [4:0] SHPP_I2C_LAST = 5'h11;
   localparam logic [1:0] SHPP_PHASE_LAST = 2'h3;
endpackage

// >>> rtl/shpp_port.sv
// Purpose: serial host port pins, spi master/slave and i2c slave, one byte at a time
// Assumes: pins are asynchronous to LINK_CLK_IN and oversampled by it
// Notes: user side on CLOCK_IN, pin side on LINK_CLK_IN, toggle crossings between
//
// What this block does
// - spi master: drive mosi, read miso
// - spi slave: drive miso, float when deselected
// - spi slave: read mosi from master
// - i2c: sda open drain, never driven high
// - sda changes only while scl low
// - idle i2c bus: nobody pulls sda low
// - start is sda falling while scl high
// - stop is sda rising while scl high
// - i2c slave address uses select pin
// - pins float during any reset
// - shift one sck edge, sample the other
// - spi slave acts only while selected
// - select asserted in master role flags error
`timescale 1ns/10ps
module shpp_port
   import shpp_pkg::*;
#(
   parameter logic [6:0] ADDR_BASE = SHPP_ADDR_BASE
) (
   input wire logic CLOCK_IN,
   input wire logic RST_IN,
   input wire logic LINK_CLK_IN,
   input wire logic SOFT_RESET_IN,
   input wire logic PORT_RESET_IN,
   input wire logic I2C_MODE_IN,
   input wire logic MASTER_IN,
   input wire logic [7:0] TX_DATA_IN,
   input wire logic TX_LOAD_IN,
   output logic [7:0] RX_DATA_OUT,
   output logic RX_VALID_OUT,
   output logic BUS_ERROR_OUT,
   shpp_link_if.dev LINK
);
   typedef enum logic [3:0] {
      D_IDLE, D_SPI_M, D_SPI_S, D_ADDR, D_ACK, D_WRITE, D_READ, D_RACK, D_WAIT_STOP
   } shpp_dstate_e;

   typedef struct packed {
      shpp_dstate_e st;
      logic [3:0] bitcnt;
      logic [7:0] div;
      logic [7:0] shift_in;
      logic [7:0] shift_out;
      logic [7:0] tx_byte;
      logic tx_seen;
      logic tx_new;
      logic rw;
      logic sck_o;
      logic mosi_o;
      logic sda_oe;
      logic [7:0] rx_data;
      logic rx_tgl;
      logic err;
   } shpp_dlink_s;

   // user clock domain
   logic rst_req_reg, rst_req_next;
   logic i2c_reg, i2c_next, master_reg, master_next;
   logic [7:0] tx_hold_reg, tx_hold_next;
   logic tx_tgl_reg, tx_tgl_next;
   logic [2:0] rx_sync_reg, rx_sync_next;
   logic [1:0] err_sync_reg, err_sync_next;
   logic [7:0] rx_out_reg, rx_out_next;
   logic rx_valid_reg, rx_valid_next;

   // link clock domain
   logic [3:0] cfg_s1_reg, cfg_s2_reg;
   logic [6:0] pin_s1_reg, pin_s2_reg;
   logic [6:0] pin_p_reg;
   shpp_dlink_s lk_reg, lk_next;
   logic rst_link, tx_tgl_s, i2c_s, master_s;
   logic sck_s, mosi_s, miso_s, ss_n_s, scl_s, sda_s, asel_s;
   logic sck_rise, sck_fall, scl_rise, scl_fall, i2c_start, i2c_stop;
   logic pins_off, spi_master, spi_slave_sel;

   always_comb begin
      rst_req_next = RST_IN | SOFT_RESET_IN | PORT_RESET_IN;
      i2c_next = I2C_MODE_IN;
      master_next = MASTER_IN;
      tx_hold_next = TX_LOAD_IN ? TX_DATA_IN : tx_hold_reg;
      tx_tgl_next = tx_tgl_reg ^ TX_LOAD_IN;
      rx_sync_next = {rx_sync_reg[1:0], lk_reg.rx_tgl};
      err_sync_next = {err_sync_reg[0], lk_reg.err};
      // rx byte is stable in the link register long before its toggle is seen here
      rx_valid_next = rx_sync_reg[2] ^ rx_sync_reg[1];
      rx_out_next = rx_valid_next ? lk_reg.rx_data : rx_out_reg;
   end

   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         rst_req_reg <= 1'h1;
         i2c_reg <= 1'h0;
         master_reg <= 1'h0;
         tx_hold_reg <= 8'h00;
         tx_tgl_reg <= 1'h0;
         rx_sync_reg <= 3'h0;
         err_sync_reg <= 2'h0;
         rx_out_reg <= 8'h00;
         rx_valid_reg <= 1'h0;
      end else begin
         rst_req_reg <= rst_req_next;
         i2c_reg <= i2c_next;
         master_reg <= master_next;
         tx_hold_reg <= tx_hold_next;
         tx_tgl_reg <= tx_tgl_next;
         rx_sync_reg <= rx_sync_next;
         err_sync_reg <= err_sync_next;
         rx_out_reg <= rx_out_next;
         rx_valid_reg <= rx_valid_next;
      end
   end

   assign RX_DATA_OUT = rx_out_reg;
   assign RX_VALID_OUT = rx_valid_reg;
   assign BUS_ERROR_OUT = err_sync_reg[1];

   // two-stage synchronisers into the link domain, no logic on stage one
   always_ff @(posedge LINK_CLK_IN) begin
      cfg_s1_reg <= {rst_req_reg, tx_tgl_reg, i2c_reg, master_reg};
      cfg_s2_reg <= cfg_s1_reg;
      pin_s1_reg <= {LINK.sck, LINK.mosi, LINK.miso, LINK.ss_n, LINK.scl, LINK.sda,
                     LINK.i2c_slave_addr_select_0};
      pin_s2_reg <= pin_s1_reg;
      pin_p_reg <= pin_s2_reg;
   end

   assign {rst_link, tx_tgl_s, i2c_s, master_s} = cfg_s2_reg;
   assign {sck_s, mosi_s, miso_s, ss_n_s, scl_s, sda_s, asel_s} = pin_s2_reg;
   assign sck_rise = sck_s & ~pin_p_reg[6];
   assign sck_fall = ~sck_s & pin_p_reg[6];
   assign scl_rise = scl_s & ~pin_p_reg[2];
   assign scl_fall = ~scl_s & pin_p_reg[2];
   assign i2c_start = scl_s & pin_p_reg[2] & pin_p_reg[1] & ~sda_s;
   assign i2c_stop = scl_s & pin_p_reg[2] & ~pin_p_reg[1] & sda_s;
   assign spi_master = ~i2c_s & master_s;
   assign spi_slave_sel = ~i2c_s & ~master_s & ~ss_n_s;

   always_comb begin
      lk_next = lk_reg;
      lk_next.err = spi_master & ~ss_n_s;
      case (lk_reg.st)
         D_IDLE: begin
            lk_next.sck_o = 1'h0;
            lk_next.sda_oe = 1'h0;
            lk_next.bitcnt = 4'h0;
            lk_next.div = 8'h00;
            // a master transfer waits while select is wrongly held low
            if (spi_master && lk_reg.tx_new && ss_n_s) begin
               lk_next.st = D_SPI_M;
               lk_next.tx_new = 1'h0;
               lk_next.shift_out = lk_reg.tx_byte;
               lk_next.mosi_o = lk_reg.tx_byte[7];
            end else if (spi_slave_sel) begin
               lk_next.st = D_SPI_S;
               lk_next.shift_out = lk_reg.tx_byte;
            end
         end
         D_SPI_M: begin
            lk_next.div = lk_reg.div + 8'h01;
            if (lk_reg.div == SHPP_DEV_SCK_HALF - 8'h01) begin
               lk_next.div = 8'h00;
               lk_next.sck_o = ~lk_reg.sck_o;
               if (!lk_reg.sck_o) begin
                  lk_next.shift_in = {lk_reg.shift_in[6:0], miso_s};
               end else if (lk_reg.bitcnt == SHPP_BYTE_BITS - 4'h1) begin
                  lk_next.rx_data = lk_reg.shift_in;
                  lk_next.rx_tgl = ~lk_reg.rx_tgl;
                  lk_next.st = D_IDLE;
               end else begin
                  lk_next.bitcnt = lk_reg.bitcnt + 4'h1;
                  lk_next.shift_out = {lk_reg.shift_out[6:0], 1'h0};
                  lk_next.mosi_o = lk_reg.shift_out[6];
               end
            end
         end
         D_SPI_S: begin
            if (!spi_slave_sel) begin
               lk_next.st = D_IDLE;
            end else if (sck_rise) begin
               lk_next.shift_in = {lk_reg.shift_in[6:0], mosi_s};
               lk_next.bitcnt = lk_reg.bitcnt + 4'h1;
               if (lk_reg.bitcnt == SHPP_BYTE_BITS - 4'h1) begin
                  lk_next.bitcnt = 4'h0;
                  lk_next.rx_data = {lk_reg.shift_in[6:0], mosi_s};
                  lk_next.rx_tgl = ~lk_reg.rx_tgl;
               end
            end else if (sck_fall) begin
               // next byte is reloaded after the last bit of the previous one
               lk_next.shift_out = (lk_reg.bitcnt == 4'h0) ? lk_reg.tx_byte : {lk_reg.shift_out[6:0], 1'h0};
            end
         end
         D_ADDR, D_WRITE: begin
            if (scl_rise) begin
               lk_next.shift_in = {lk_reg.shift_in[6:0], sda_s};
               lk_next.bitcnt = lk_reg.bitcnt + 4'h1;
            end else if (scl_fall && lk_reg.bitcnt == SHPP_BYTE_BITS) begin
               lk_next.bitcnt = 4'h0;
               if (lk_reg.st == D_WRITE) begin
                  lk_next.rx_data = lk_reg.shift_in;
                  lk_next.rx_tgl = ~lk_reg.rx_tgl;
                  lk_next.sda_oe = 1'h1;
                  lk_next.st = D_ACK;
               end else if (lk_reg.shift_in[7:1] == {ADDR_BASE[6:1], asel_s}) begin
                  lk_next.rw = lk_reg.shift_in[0];
                  lk_next.sda_oe = 1'h1;
                  lk_next.st = D_ACK;
               end else begin
                  lk_next.st = D_WAIT_STOP;
               end
            end
         end
         D_ACK: begin
            if (scl_fall) begin
               lk_next.bitcnt = 4'h0;
               if (lk_reg.rw) begin
                  lk_next.st = D_READ;
                  lk_next.shift_out = lk_reg.tx_byte;
                  lk_next.sda_oe = ~lk_reg.tx_byte[7];
               end else begin
                  lk_next.st = D_WRITE;
                  lk_next.sda_oe = 1'h0;
               end
            end
         end
         D_READ: begin
            if (scl_rise) begin
               lk_next.bitcnt = lk_reg.bitcnt + 4'h1;
            end else if (scl_fall) begin
               if (lk_reg.bitcnt == SHPP_BYTE_BITS) begin
                  lk_next.sda_oe = 1'h0;
                  lk_next.st = D_RACK;
               end else begin
                  lk_next.shift_out = {lk_reg.shift_out[6:0], 1'h0};
                  lk_next.sda_oe = ~lk_reg.shift_out[6];
               end
            end
         end
         D_RACK: begin
            // master nack ends the read, ack asks for another byte
            if (scl_rise) begin
               lk_next.st = sda_s ? D_WAIT_STOP : D_ACK;
            end
         end
         D_WAIT_STOP: begin
            lk_next.sda_oe = 1'h0;
         end
         default: begin
            lk_next.st = D_IDLE;
         end
      endcase
      // i2c master role is not served here, so the select pin is never read then
      if (i2c_s && !master_s && i2c_start) begin
         lk_next.st = D_ADDR;
         lk_next.bitcnt = 4'h0;
         lk_next.sda_oe = 1'h0;
      end else if (i2c_s && i2c_stop) begin
         lk_next.st = D_IDLE;
         lk_next.sda_oe = 1'h0;
      end else if (!i2c_s && lk_reg.st >= D_ADDR) begin
         lk_next.st = D_IDLE;
         lk_next.sda_oe = 1'h0;
      end
      // captured last so that a new byte is never lost behind a consume
      if (tx_tgl_s != lk_reg.tx_seen) begin
         lk_next.tx_seen = tx_tgl_s;
         lk_next.tx_byte = tx_hold_reg;
         lk_next.tx_new = 1'h1;
      end
      // a byte loaded before a reset is dropped, never sent once the reset ends
      if (rst_link) begin
         lk_next = '0;
         lk_next.tx_seen = tx_tgl_s;
      end
   end

   always_ff @(posedge LINK_CLK_IN) begin
      lk_reg <= lk_next;
   end

   // user-domain reset floats pins at once, the link copy covers the rest
   assign pins_off = rst_req_reg | rst_link;
   assign LINK.sck_dev_o = lk_reg.sck_o;
   assign LINK.sck_dev_oe = spi_master & ~pins_off;
   assign LINK.mosi_dev_o = lk_reg.mosi_o;
   assign LINK.mosi_dev_oe = spi_master & ~pins_off;
   assign LINK.miso_dev_o = lk_reg.shift_out[7];
   assign LINK.miso_dev_oe = (lk_reg.st == D_SPI_S) & ~ss_n_s & ~pins_off;
   assign LINK.sda_dev_oe = lk_reg.sda_oe & i2c_s & ~pins_off;
endmodule

// >>> testbench/serial_host_port_pins_tb_top.sv
// Purpose: both ends joined, byte exchange in both spi roles and as i2c slave, device i2c master role stays silent
// Assumes: inputs change on the falling CLOCK_IN edge
// Notes: row table first, then bus error and mid-byte resets
`timescale 1ns/10ps
module serial_host_port_pins_tb_top;
   import shpp_pkg::*;
   typedef struct {logic i2c, dm, rd, sel; logic [6:0] ad; logic [7:0] dt, ft, ed, ef; logic dv, fv, ak;} shpp_row_s;
   logic clk, lclk, rst, prst, srst, im, dm, fm, ld, st, rd, sel, ssf, dvl, fvl, berr, busy, ack, dgot, fgot;
   logic [6:0] ad;
   logic [7:0] dt, ft, drx, frx, dby, fby;
   int err_total, check_count;
   shpp_row_s rows [6];
   shpp_row_s r;
   shpp_link_if lk ();
   shpp_port shpp_port_i (.CLOCK_IN(clk), .RST_IN(rst), .LINK_CLK_IN(lclk), .SOFT_RESET_IN(srst),
      .PORT_RESET_IN(prst), .I2C_MODE_IN(im), .MASTER_IN(dm), .TX_DATA_IN(dt), .TX_LOAD_IN(ld),
      .RX_DATA_OUT(drx), .RX_VALID_OUT(dvl), .BUS_ERROR_OUT(berr), .LINK(lk.dev));
   shpp_far_end shpp_far_end_i (.CLOCK_IN(clk), .RST_IN(rst), .I2C_MODE_IN(im), .MASTER_IN(fm),
      .START_IN(st), .ADDR_IN(ad), .READ_IN(rd), .TX_DATA_IN(ft), .ADDR_SEL_IN(sel), .SS_FORCE_IN(ssf),
      .BUSY_OUT(busy), .RX_DATA_OUT(frx), .RX_VALID_OUT(fvl), .ACK_OK_OUT(ack), .LINK(lk.par));
   shpp_properties shpp_properties_i (.LINK_CLK_IN(lclk), .RST_IN(rst), .sck(lk.sck), .sda(lk.sda),
      .scl(lk.scl), .ss_n(lk.ss_n), .sck_dev_oe(lk.sck_dev_oe), .mosi_dev_o(lk.mosi_dev_o),
      .mosi_dev_oe(lk.mosi_dev_oe), .miso_dev_o(lk.miso_dev_o), .miso_dev_oe(lk.miso_dev_oe),
      .sda_dev_oe(lk.sda_dev_oe));
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   initial begin
      lclk = 1'h0;
      #7.3;
      forever #15 lclk = ~lclk;
   end
   always @(posedge clk) if (dvl === 1'h1) {dgot, dby} = {1'h1, drx};
   always @(posedge clk) if (fvl === 1'h1) {fgot, fby} = {1'h1, frx};
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk1(input logic g, input logic e);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %0t bit got %b exp %b", $time, g, e);
      end
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %0t byte got %h exp %h", $time, g, e);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #120000;
      err_total++;
      give_verdict;
   end
   initial begin
      {rst, prst, srst, ssf, ld, st, rd, sel, im, dm, fm, dgot, fgot} = 13'h1800;
      {ad, dt, ft} = 23'h00_0000;
      err_total = 0;
      check_count = 0;
      rows[0] = '{1'h0, 1'h1, 1'h0, 1'h0, 7'h00, 8'ha5, 8'h3c, 8'h3c, 8'ha5, 1'h1, 1'h1, 1'h1};
      rows[1] = '{1'h0, 1'h0, 1'h0, 1'h0, 7'h00, 8'h5a, 8'h96, 8'h96, 8'h5a, 1'h1, 1'h1, 1'h1};
      rows[2] = '{1'h1, 1'h0, 1'h0, 1'h1, 7'h49, 8'h00, 8'hc3, 8'hc3, 8'h00, 1'h1, 1'h0, 1'h1};
      rows[3] = '{1'h1, 1'h0, 1'h1, 1'h0, 7'h48, 8'h7e, 8'h00, 8'h00, 8'h7e, 1'h0, 1'h1, 1'h1};
      rows[4] = '{1'h1, 1'h0, 1'h0, 1'h0, 7'h49, 8'h00, 8'h11, 8'h00, 8'h00, 1'h0, 1'h0, 1'h0};
      // device in i2c master role must ignore the select pin and stay silent
      rows[5] = '{1'h1, 1'h1, 1'h0, 1'h1, 7'h49, 8'h00, 8'h11, 8'h00, 8'h00, 1'h0, 1'h0, 1'h0};
      cyc(5);
      chk1(lk.sck_dev_oe | lk.mosi_dev_oe | lk.miso_dev_oe | lk.sda_dev_oe, 1'h0);
      cyc(5);
      rst = 1'h0;
      cyc(30);
      prst = 1'h0;
      cyc(40);
      foreach (rows[i]) begin
         r = rows[i];
         {im, dm, fm, rd, sel, ad, dt, ft} = {r.i2c, r.dm, r.i2c | ~r.dm, r.rd, r.sel, r.ad, r.dt, r.ft};
         {dgot, fgot} = 2'h0;
         cyc(40);
         // far slave must hold its reply before the device master starts
         st = r.dm;
         cyc(1);
         st = 1'h0;
         ld = 1'h1;
         cyc(1);
         ld = 1'h0;
         cyc(80);
         st = ~r.dm;
         cyc(1);
         st = 1'h0;
         for (int k = 0; k < 4000 && (busy !== 1'h0 || (r.dv && !dgot)); k++) cyc(1);
         chk1(busy, 1'h0);
         cyc(100);
         chk1(dgot, r.dv);
         if (r.dv) chk8(dby, r.ed);
         if (r.fv) chk8(fby, r.ef);
         if (r.i2c && !r.rd) chk1(ack, r.ak);
         chk1(lk.miso_dev_oe, 1'h0);
         chk1(lk.sda, 1'h1);
      end
      {im, dm, fm, dgot, ssf} = 5'h09;
      cyc(40);
      chk1(berr, 1'h1);
      ld = 1'h1;
      cyc(1);
      ld = 1'h0;
      cyc(300);
      chk1(dgot, 1'h0);
      ssf = 1'h0;
      cyc(40);
      chk1(berr, 1'h0);
      cyc(700);
      chk1(dgot, 1'h1);
      for (int k = 0; k < 2; k++) begin
         ld = 1'h1;
         cyc(1);
         ld = 1'h0;
         cyc(60);
         chk1(lk.sck_dev_oe, 1'h1);
         {srst, prst, dgot} = (k == 0) ? 3'h4 : 3'h2;
         cyc(40);
         chk1(lk.sck_dev_oe | lk.mosi_dev_oe | lk.miso_dev_oe | lk.sda_dev_oe, 1'h0);
         {srst, prst} = 2'h0;
         cyc(800);
         chk1(dgot, 1'h0);
      end
      give_verdict;
   end
endmodule

// >>> testbench/shpp_properties.sv
// Purpose: pin rules of the device end, watched on the link
// Assumes: link clock oversamples the resolved pins
// Notes: oe high means driving, or pulling low on sda
`timescale 1ns/10ps
module shpp_properties (
   input wire logic LINK_CLK_IN,
   input wire logic RST_IN,
   input wire logic sck,
   input wire logic sda,
   input wire logic scl,
   input wire logic ss_n,
   input wire logic sck_dev_oe,
   input wire logic mosi_dev_o,
   input wire logic mosi_dev_oe,
   input wire logic miso_dev_o,
   input wire logic miso_dev_oe,
   input wire logic sda_dev_oe
);
   default clocking @(posedge LINK_CLK_IN); endclocking
   default disable iff (RST_IN);
   logic [5:0] idle_reg;
   logic [5:0] idle_next;
   // saturates so a long idle bus keeps the check armed
   always_comb idle_next = (RST_IN || !scl) ? 6'h00 : idle_reg + {5'h00, idle_reg != 6'h28};
   always_ff @(posedge LINK_CLK_IN) idle_reg <= idle_next;
   sequence s_scl_high2; scl ##1 scl; endsequence
   property p_reset_float;
      disable iff (1'h0) RST_IN [*2] |-> !(sck_dev_oe | mosi_dev_oe | miso_dev_oe | sda_dev_oe);
   endproperty
   a_reset_float: assert property (p_reset_float) else $error("pin driven in reset");
   property p_master_pins; sck_dev_oe |-> mosi_dev_oe && !miso_dev_oe; endproperty
   a_master_pins: assert property (p_master_pins) else $error("master pin roles");
   property p_slave_pins; miso_dev_oe |-> !mosi_dev_oe && !sck_dev_oe; endproperty
   a_slave_pins: assert property (p_slave_pins) else $error("slave pin roles");
   property p_miso_float; ss_n [*5] |-> !miso_dev_oe; endproperty
   a_miso_float: assert property (p_miso_float) else $error("miso driven unselected");
   property p_select_first; $rose(miso_dev_oe) |-> !$past(ss_n, 2); endproperty
   a_select_first: assert property (p_select_first) else $error("miso driven before select");
   property p_mosi_shift; sck_dev_oe && $changed(mosi_dev_o) |-> !sck; endproperty
   a_mosi_shift: assert property (p_mosi_shift) else $error("mosi moved with sck high");
   property p_miso_shift; miso_dev_oe && $past(miso_dev_oe) && $changed(miso_dev_o) |-> !sck; endproperty
   a_miso_shift: assert property (p_miso_shift) else $error("miso moved with sck high");
   property p_sda_stable; s_scl_high2 |-> $stable(sda_dev_oe); endproperty
   a_sda_stable: assert property (p_sda_stable) else $error("sda moved with scl high");
   property p_sda_idle; idle_reg == 6'h28 |-> !sda_dev_oe; endproperty
   a_sda_idle: assert property (p_sda_idle) else $error("sda pulled on idle bus");
   property p_sda_only; sda_dev_oe |-> !sck_dev_oe && !miso_dev_oe; endproperty
   a_sda_only: assert property (p_sda_only) else $error("spi pins driven in i2c");
endmodule
